// *** ebswc_ctrl.v ***
// external bus controller: strobes, wait states and the address/data pins
`timescale 1ns/1ps
`include "ebswc_map.vh"

// Summary of operation
// R1: byte-high enable on word and high-byte writes
// R2: write-high strobe: high/word writes, all 8-bit writes
// R3: style bit one selects enable, zero strobe
// R4: sample ready on clock_output falls, wait while low
// R5: stop waiting on ready high or limit
// R6: only external accesses use ready
// R7: bit 15 address-only on 8-bit, multiplexed 16-bit
// R8: write-low strobe: low/word writes, all 8-bit writes
// R9: enable mode: low pin is plain write strobe
// R10: read strobe only in external read cycles
// R11: wait counter cleared at each bus cycle start
module ebswc_ctrl (
    input  wire                        clk_sys,
    input  wire                        rstn,
    input  wire                        req_valid,
    input  wire                        req_write,
    input  wire                        req_ext,
    input  wire                        req_word,
    input  wire [15:0]                 req_addr,
    input  wire [15:0]                 req_wdata,
    input  wire                        bus16,
    input  wire                        write_strobe_style_bit,
    input  wire                        wait_limit_bit_lo,
    input  wire                        wait_limit_bit_hi,
    input  wire                        ready,
    input  wire [15:0]                 ad_in,
    output reg  [15:0]                 ad_out,
    output reg  [15:0]                 ad_oe,
    output reg                         ale,
    output reg                         clock_output,
    output reg                         rd_n,
    output reg                         low_strobe_pin_n,
    output reg                         high_strobe_pin_n,
    output reg                         busy,
    output reg                         done,
    output reg  [15:0]                 rdata
);

    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_ADDR = 5'b00010;
    localparam [4:0] ST_STRB = 5'b00100;
    localparam [4:0] ST_HOLD = 5'b01000;
    localparam [4:0] ST_INT  = 5'b10000;

    reg  [4:0]                 st;
    reg                        l_write;
    reg                        l_word;
    reg  [15:0]                l_addr;
    reg  [15:0]                l_wdata;
    reg                        l_bus16;
    reg                        l_style;
    reg  [`EBSWC_LIMIT_W-1:0]  l_limit;
    reg                        hi_phase;
    reg                        wclear;
    wire                       fall;
    wire                       wsample;
    wire                       whit;
    wire [15:0]                addr8;
    wire [7:0]                 wbyte;
    wire                       lane_lo16;
    wire                       lane_hi16;
    wire                       hi_en_on;
    wire                       wr_lo_on;
    wire                       wr_hi_on;

    // clock_output is high now, so this edge is its falling edge
    assign fall    = clock_output;
    assign wsample = st[2] & fall; // see R4

    // 8-bit bus: low address bit names the byte of this cycle
    assign addr8   = {l_addr[15:1], hi_phase};
    assign wbyte   = hi_phase ? l_wdata[15:8] : l_wdata[7:0];

    assign lane_lo16 = l_word | ~l_addr[0];
    assign lane_hi16 = l_word | l_addr[0];

    assign hi_en_on = l_write & (l_bus16 ? lane_hi16 : hi_phase); // see R1
    assign wr_lo_on = l_write & (l_bus16 ? lane_lo16 : 1'b1);     // see R8
    assign wr_hi_on = l_write & (l_bus16 ? lane_hi16 : 1'b1);     // see R2

    ebswc_wait ebswc_wait_i (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clear   (wclear),
        .sample  (wsample),
        .ready   (ready),
        .limit   (l_limit),
        .hit     (whit),
        .count   ()
    );

    // free-running divide by two of the core clock
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clock_output <= `EBSWC_RST_CLK_OUT;
        end else begin
            clock_output <= ~clock_output;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st                <= ST_IDLE;
            l_write           <= 1'b0;
            l_word            <= 1'b0;
            l_addr            <= `EBSWC_RST_AD;
            l_wdata           <= `EBSWC_RST_AD;
            l_bus16           <= `EBSWC_BUS_16;
            l_style           <= `EBSWC_STYLE_STROBE;
            l_limit           <= `EBSWC_RST_CNT;
            hi_phase          <= 1'b0;
            wclear            <= 1'b0;
            ad_out            <= `EBSWC_RST_AD;
            ad_oe             <= `EBSWC_OE_NONE;
            ale               <= 1'b0;
            rd_n              <= `EBSWC_RST_STROBE_N;
            low_strobe_pin_n  <= `EBSWC_RST_STROBE_N;
            high_strobe_pin_n <= `EBSWC_RST_STROBE_N;
            busy              <= 1'b0;
            done              <= 1'b0;
            rdata             <= `EBSWC_RST_AD;
        end else begin
            wclear <= 1'b0;
            done   <= 1'b0;
            case (st)
                ST_IDLE: begin
                    if (req_valid) begin
                        busy    <= 1'b1;
                        l_write <= req_write;
                        l_word  <= req_word;
                        l_addr  <= req_addr;
                        l_wdata <= req_wdata;
                        l_bus16 <= bus16;
                        l_style <= write_strobe_style_bit; // see R3
                        l_limit <= {wait_limit_bit_hi, wait_limit_bit_lo};
                        if (!req_ext) begin
                            // internal access: no pins move, ready not looked at
                            st <= ST_INT; // see R6
                        end else begin
                            st       <= ST_ADDR;
                            wclear   <= 1'b1; // see R11
                            ale      <= 1'b1;
                            ad_oe    <= `EBSWC_OE_ALL;
                            hi_phase <= ~bus16 & ~req_word & req_addr[0];
                            if (bus16) begin
                                ad_out <= req_addr;
                            end else begin
                                ad_out <= {req_addr[15:1], ~req_word & req_addr[0]};
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    // address phase lasts until the next falling clock_output edge
                    if (fall) begin
                        st   <= ST_STRB;
                        ale  <= 1'b0;
                        rd_n <= l_write; // see R10
                        if (l_style == `EBSWC_STYLE_ENABLE) begin
                            low_strobe_pin_n  <= ~l_write;   // see R9
                            high_strobe_pin_n <= ~hi_en_on;  // see R1
                        end else begin
                            low_strobe_pin_n  <= ~wr_lo_on;  // see R8
                            high_strobe_pin_n <= ~wr_hi_on;  // see R2
                        end
                        if (l_bus16 == `EBSWC_BUS_16) begin
                            // bit 15 joins the data lanes here  // see R7
                            ad_out <= l_wdata;
                            ad_oe  <= l_write ? `EBSWC_OE_ALL : `EBSWC_OE_NONE;
                        end else begin
                            // upper pins keep the address for the whole cycle  // see R7
                            ad_out <= {addr8[15:8], wbyte};
                            ad_oe  <= {`EBSWC_OE_BYTE_ON,
                                       l_write ? `EBSWC_OE_BYTE_ON : `EBSWC_OE_BYTE_OFF};
                        end
                    end
                end
                ST_STRB: begin
                    // whit is only true on a falling edge with ready high or at limit
                    if (whit) begin // see R5
                        st                <= ST_HOLD;
                        rd_n              <= `EBSWC_RST_STROBE_N;
                        low_strobe_pin_n  <= `EBSWC_RST_STROBE_N;
                        high_strobe_pin_n <= `EBSWC_RST_STROBE_N;
                        if (!l_write) begin
                            if (l_bus16) begin
                                rdata <= ad_in;
                            end else if (hi_phase) begin
                                rdata[15:8] <= ad_in[7:0];
                            end else begin
                                rdata[7:0] <= ad_in[7:0];
                            end
                        end
                    end
                end
                ST_HOLD: begin
                    if (!l_bus16 && l_word && !hi_phase) begin
                        // 8-bit bus word: second cycle for the high byte
                        st       <= ST_ADDR;
                        hi_phase <= 1'b1;
                        wclear   <= 1'b1; // see R11
                        ale      <= 1'b1;
                        ad_oe    <= `EBSWC_OE_ALL;
                        ad_out   <= {l_addr[15:1], 1'b1};
                    end else begin
                        st    <= ST_IDLE;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                        ad_oe <= `EBSWC_OE_NONE;
                    end
                end
                ST_INT: begin
                    st   <= ST_IDLE;
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                default: begin
                    st <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// *** ebswc_ctrl_asserts.sv ***
// port assertions for the external bus controller
`timescale 1ns/1ps
module ebswc_ctrl_asserts (
    input wire        clk_sys,
    input wire        rstn,
    input wire        req_valid,
    input wire        req_ext,
    input wire        bus16,
    input wire        write_strobe_style_bit,
    input wire        wait_limit_bit_lo,
    input wire        wait_limit_bit_hi,
    input wire        ready,
    input wire [15:0] ad_oe,
    input wire        ale,
    input wire        clock_output,
    input wire        rd_n,
    input wire        low_strobe_pin_n,
    input wire        high_strobe_pin_n,
    input wire        busy,
    input wire        done
);
    wire strb = !(rd_n && low_strobe_pin_n && high_strobe_pin_n);
    wire take = req_valid && !busy;
    wire lim0 = !wait_limit_bit_hi && !wait_limit_bit_lo;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_read_quiet: assert property (!rd_n |-> low_strobe_pin_n && high_strobe_pin_n)
        else $error("write strobe during read");
    chk_strobe_busy: assert property (strb |-> busy)
        else $error("strobe outside a bus cycle");
    chk_internal_quiet: assert property (take && !req_ext |=> !ale && !strb && busy ##1 !ale && !strb && done)
        else $error("pin activity on internal access");
    chk_cycle_start: assert property (take && req_ext |=> ale && busy)
        else $error("external cycle did not start");
    chk_ready_end: assert property (strb && clock_output && ready |=> !strb)
        else $error("strobe kept after ready high");
    chk_limit_zero: assert property (strb && clock_output && lim0 |=> !strb)
        else $error("wait inserted with limit zero");
    chk_wait_held: assert property ($rose(strb) ##1 (clock_output && !ready && !lim0) |=> strb)
        else $error("no wait state with ready low");
    chk_enable_style: assert property (write_strobe_style_bit && !high_strobe_pin_n |-> !low_strobe_pin_n)
        else $error("enable without write strobe");
    chk_bit15_addr: assert property (strb && !bus16 |-> ad_oe[15:8] == 8'hff)
        else $error("upper address dropped on narrow bus");
    chk_read_release: assert property (!rd_n |-> ad_oe[7:0] == 8'h00)
        else $error("low lanes driven during read");
    cover property (strb && clock_output && !ready);
    cover property (!high_strobe_pin_n && low_strobe_pin_n);
    cover property (!rd_n ##2 done);
endmodule

bind ebswc_ctrl ebswc_ctrl_asserts ebswc_ctrl_asserts_i (.*);

// *** ebswc_ctrl_tb_top.sv ***
// testbench for the external bus controller
`timescale 1ns/1ps
module ebswc_ctrl_tb_top;
    reg         clk_sys = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    reg         req_ext = 1'b0, req_word = 1'b0, bus16 = 1'b0, style = 1'b0;
    reg  [1:0]  lim = 2'h0;
    reg  [2:0]  seen = 3'h0;
    reg  [7:0]  wait_n = 8'hff;
    reg  [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, rd_val = 16'h0000;
    reg         a15 = 1'b0, mon_clr = 1'b0;
    wire [15:0] ad_out, ad_oe, ad_in, rdata;
    wire        ready, ale, clock_output, rd_n, lo_n, hi_n, busy, done;
    integer     num_errors = 0, compares = 0, width = 0;
    ebswc_ctrl ebswc_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
        .req_write(req_write), .req_ext(req_ext), .req_word(req_word), .req_addr(req_addr),
        .req_wdata(req_wdata), .bus16(bus16), .write_strobe_style_bit(style),
        .wait_limit_bit_lo(lim[0]), .wait_limit_bit_hi(lim[1]), .ready(ready), .ad_in(ad_in),
        .ad_out(ad_out), .ad_oe(ad_oe), .ale(ale), .clock_output(clock_output), .rd_n(rd_n),
        .low_strobe_pin_n(lo_n), .high_strobe_pin_n(hi_n), .busy(busy), .done(done),
        .rdata(rdata));
    ebswc_mem ebswc_mem_i (.clk_sys(clk_sys), .rstn(rstn), .rd_n(rd_n), .low_strobe_pin_n(lo_n),
        .high_strobe_pin_n(hi_n), .ad_out(ad_out), .ad_oe(ad_oe), .wait_n(wait_n),
        .rd_val(rd_val), .ready(ready), .ad_in(ad_in));
    always #4 clk_sys = ~clk_sys;
    // monitor owns seen and width; tasks only ask for a clear
    always @(posedge clk_sys) begin
        if (mon_clr) begin
            seen  <= 3'h0;
            width <= 0;
        end else begin
            seen <= seen | {!rd_n, !hi_n, !lo_n};
            if (!(lo_n && hi_n && rd_n)) begin
                width <= width + 1;
                a15 <= ad_oe[15] ? ad_out[15] : 1'bx;
            end
        end
    end
    task chk(input [15:0] got, input [15:0] exp, input [8*12:1] msg);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: %0s got %h exp %h", $time, msg, got, exp);
            end
        end
    endtask
    task xfer(input w, input e, input wd, input [15:0] a, input [15:0] d);
        integer n;
        begin
            @(negedge clk_sys);
            {req_write, req_ext, req_word, req_addr, req_wdata} = {w, e, wd, a, d};
            mon_clr = 1'b1;
            req_valid = 1'b1;
            n = 0;
            @(negedge clk_sys);
            req_valid = 1'b0;
            mon_clr = 1'b0;
            while (done !== 1'b1 && n < 100) begin
                @(negedge clk_sys);
                n = n + 1;
            end
            if (n == 100) chk(0, 1, "no done");
        end
    endtask
    task t_internal;
        begin
            xfer(1, 0, 1, 16'h0010, 16'h1234);
            chk(seen, 0, "internal");
            $display("test internal done");
        end
    endtask
    task t_strobes;
        integer j;
        begin
            for (j = 0; j < 12; j = j + 1) begin
                {style, bus16} = 2'(j / 3);
                xfer(1, 1, j % 3 == 0, {15'h1230, j % 3 == 1}, 16'ha55a);
                chk(seen, {(j % 3 != 2) | (!style & !bus16), style | !bus16 | (j % 3 != 1)},
                    "strobes");
            end
            $display("test strobes done");
        end
    endtask
    task t_wait;
        integer l;
        begin
            bus16 = 1'b1;
            for (l = 0; l < 4; l = l + 1) begin
                lim = 2'(l);
                xfer(1, 1, 1, 16'h0020, 16'h0f0f);
                chk(width, 2 + 2 * l, "wait width");
            end
            // a counter left over from the last cycle would end this one early
            wait_n = 8'h03;
            rd_val = 16'hc3a5;
            xfer(0, 1, 1, 16'h0040, 16'h0000);
            chk(width, 4, "ready end");
            chk(rdata, 16'hc3a5, "read data");
            chk(seen, 3'h4, "read strobe");
            // narrow bus word read: two byte cycles, each with its own wait count
            bus16 = 1'b0;
            rd_val = 16'h5a3c;
            xfer(0, 1, 1, 16'h0060, 16'h0000);
            chk(width, 8, "narrow width");
            chk(rdata, 16'h3c3c, "narrow read");
            chk(seen, 3'h4, "narrow strb");
            $display("test wait done");
        end
    endtask
    task t_bit15;
        begin
            bus16 = 1'b0;
            xfer(1, 1, 0, 16'h8001, 16'h0000);
            chk(a15, 1'b1, "bit15 addr");
            bus16 = 1'b1;
            xfer(1, 1, 1, 16'h8000, 16'h0000);
            chk(a15, 1'b0, "bit15 data");
            $display("test bit15 done");
        end
    endtask
    task give_verdict;
        begin
            $display("compares %0d num_errors %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        chk({rd_n, lo_n, hi_n, ale, busy, done}, 6'h38, "reset");
        t_internal;
        t_strobes;
        t_wait;
        t_bit15;
        give_verdict;
    end
    initial begin
        #100000;
        num_errors = num_errors + 1;
        give_verdict;
    end
endmodule

// *** ebswc_map.vh ***
// constants for the external bus strobe and wait-state controller
`ifndef EBSWC_MAP_VH
`define EBSWC_MAP_VH

// write_strobe_style_bit encodings
`define EBSWC_STYLE_ENABLE   1'b1
`define EBSWC_STYLE_STROBE   1'b0

// bus width select encodings
`define EBSWC_BUS_16         1'b1
`define EBSWC_BUS_8          1'b0

// field widths and lane positions
`define EBSWC_LIMIT_W        2
`define EBSWC_LANE_LO_MSB    7
`define EBSWC_LANE_HI_LSB    8
`define EBSWC_ADDR_MSB       15

// reset values
`define EBSWC_RST_STROBE_N   1'b1
`define EBSWC_RST_AD         16'h0000
`define EBSWC_RST_CNT        2'h0
`define EBSWC_RST_CLK_OUT    1'b0

// lane enables
`define EBSWC_OE_ALL         16'hffff
`define EBSWC_OE_NONE        16'h0000
`define EBSWC_OE_BYTE_ON     8'hff
`define EBSWC_OE_BYTE_OFF    8'h00

`endif

// *** ebswc_mem.sv ***
// slow external memory: ready and read data
`timescale 1ns/1ps
module ebswc_mem (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire        rd_n,
    input  wire        low_strobe_pin_n,
    input  wire        high_strobe_pin_n,
    input  wire [15:0] ad_out,
    input  wire [15:0] ad_oe,
    input  wire [7:0]  wait_n,
    input  wire [15:0] rd_val,
    output wire        ready,
    output wire [15:0] ad_in
);
    reg  [7:0]  cnt;
    reg  [15:0] last;
    wire        strb = !(rd_n && low_strobe_pin_n && high_strobe_pin_n);
    // high unless a strobe is still inside its slow window
    assign ready = !(strb && cnt < wait_n);
    // released lines flip each cycle outside a read (rd_val while rd_n is low) so a stale value never matches
    assign ad_in = (ad_oe & ad_out) | (~ad_oe & (rd_n ? ~last : rd_val));
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt <= 8'h00;
            last <= 16'h0000;
        end else begin
            cnt <= strb ? cnt + 8'h01 : 8'h00;
            last <= ad_in;
        end
    end
endmodule

// *** ebswc_wait.v ***
// wait-state counter for one external bus cycle
`timescale 1ns/1ps
`include "ebswc_map.vh"

module ebswc_wait (
    input  wire                        clk_sys,
    input  wire                        rstn,
    input  wire                        clear,
    input  wire                        sample,
    input  wire                        ready,
    input  wire [`EBSWC_LIMIT_W-1:0]   limit,
    output wire                        hit,
    output wire [`EBSWC_LIMIT_W-1:0]   count
);

    reg [`EBSWC_LIMIT_W-1:0] cnt;

    // strobe ends on ready high or once the count reaches the limit  // see R5
    assign hit   = sample & (ready | (cnt == limit));
    assign count = cnt;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt <= `EBSWC_RST_CNT;
        end else if (clear) begin
            cnt <= `EBSWC_RST_CNT; // see R11
        end else if (sample && !hit) begin
            cnt <= cnt + 1'b1; // see R4
        end
    end

endmodule
